/* bench/host_model.sv */
/*
 Host side of the register port: single reads and writes by command byte.
 Assumes the readout block answers every request with a one-cycle ack.
*/
`timescale 1ns/1ns
module host_model (
   input wire logic mclk_i,
   output temp_value_pkg::reg_req_type req_o,
   input wire temp_value_pkg::reg_rsp_type rsp_i
);
   import temp_value_pkg::*;
   initial begin
      req_o = '0;
   end
   // ----------------------------------------
   // One access, driven on falling edges
   // ----------------------------------------
   task automatic access(input logic rd, input logic [7:0] cmd, output logic [7:0] data, output logic refused);
      int i;
      logic ok;
      ok = 1'b0;
      data = 'x;
      refused = 'x;
      @(negedge mclk_i);
      req_o <= '{rd: rd, wr: !rd, cmd: cmd};
      @(negedge mclk_i);
      req_o <= '0;
      for (i = 0; i < 3; i++) begin
         if (!ok && rsp_i.ack === 1'b1) begin
            ok = 1'b1;
            data = rsp_i.data;
            refused = rsp_i.wr_refused;
         end
         if (!ok) @(negedge mclk_i);
      end
   endtask
   // Upper byte first, then lower
   task automatic read_pair(input int p, output logic [7:0] w, output logic [7:0] f);
      logic r;
      access(1'b1, WHOLE_CMD[p], w, r);
      access(1'b1, FRAC_CMD[p], f, r);
   endtask
endmodule

/* bench/temp_value_readout_regs_tb.sv */
/*
 Self-checking bench of the temperature value readout registers.
 Assumes the host model drives the register port on falling edges.
*/
`timescale 1ns/1ns
module temp_value_readout_regs_tb;
   import temp_value_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   conv_result_type conv = '0;
   logic conv_valid = 1'b0;
   logic [1:0] filt_en = 2'b00;
   logic [7:0] limit = 8'h00;
   reg_req_type req;
   reg_rsp_type rsp;
   logic over;
   logic [4:0] hold;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [7:0] w, f, d;
   logic r;
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   temp_value_readout_regs uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_i(conv), .conv_valid_i(conv_valid),
      .filt_en_i(filt_en), .local_limit_i(limit), .req_i(req), .rsp_o(rsp), .local_over_o(over),
      .hold_active_o(hold));
   host_model host (.mclk_i(mclk_i), .req_o(req), .rsp_i(rsp));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic load(input logic [7:0] lw, input logic [2:0] lf, input logic [8:0] aw, input logic [4:0] af,
      input logic [8:0] bw, input logic [4:0] bf);
      @(negedge mclk_i);
      conv.local_s <= '{lw, lf};
      conv.remote_s[0] <= '{aw, af};
      conv.remote_s[1] <= '{bw, bf};
      conv_valid <= 1'b1;
      @(negedge mclk_i);
      conv_valid <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      host.access(1'b1, cmd, d, r);
      check(d, exp);
   endtask
   task automatic lim(input logic [7:0] v, input logic exp);
      limit <= v;
      repeat (3) @(negedge mclk_i);
      check({7'h0, over}, {7'h0, exp});
   endtask
   initial begin
      #100000;
      n_mismatch++;
      $display("Watchdog expired");
      end_of_test();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_n_i <= 1'b1;
      @(negedge mclk_i);
      check({3'h0, hold}, 8'h00);
      rd(CMD_LOCAL_WHOLE, 8'h00);
      $display("Test reset done");
      filt_en <= 2'b01;
      load(8'hE7, 3'h5, 9'h064, 5'h17, 9'h0C8, 5'h0D);
      host.read_pair(PAIR_LOCAL, w, f);
      check(w, 8'hE7);
      check(f, 8'hA0);
      rd(CMD_R1S_WHOLE, 8'h64);
      rd(CMD_R1S_FRAC, 8'hB8);
      rd(CMD_R1U_WHOLE, 8'h64);
      rd(CMD_R1U_FRAC, 8'hB8);
      rd(CMD_R2S_WHOLE, 8'h7F);
      rd(CMD_R2S_FRAC, 8'hE0);
      rd(CMD_R2U_WHOLE, 8'hC8);
      rd(CMD_R2U_FRAC, 8'h60);
      filt_en <= 2'b10;
      rd(CMD_R2U_FRAC, 8'h68);
      rd(CMD_R1U_FRAC, 8'hA0);
      load(8'h7F, 3'h7, 9'h1F6, 5'h08, 9'h0FF, 5'h1F);
      rd(CMD_R1S_WHOLE, 8'hF6);
      rd(CMD_R1S_FRAC, 8'h40);
      rd(CMD_R1U_WHOLE, 8'h00);
      rd(CMD_R2U_WHOLE, 8'hFF);
      rd(CMD_LOCAL_WHOLE, 8'h7F);
      lim(8'h7F, 1'b0);
      lim(8'h7E, 1'b1);
      lim(8'h80, 1'b1);
      $display("Test formats done");
      load(8'h10, 3'h5, 9'h000, 5'h00, 9'h000, 5'h00);
      rd(CMD_LOCAL_WHOLE, 8'h10);
      check({7'h0, hold[0]}, 8'h01);
      load(8'h11, 3'h3, 9'h000, 5'h00, 9'h000, 5'h00);
      rd(CMD_LOCAL_FRAC, 8'hA0);
      check({7'h0, hold[0]}, 8'h00);
      rd(CMD_LOCAL_FRAC, 8'h60);
      rd(CMD_LOCAL_WHOLE, 8'h11);
      load(8'h11, 3'h1, 9'h005, 5'h10, 9'h000, 5'h00);
      rd(CMD_LOCAL_WHOLE, 8'h11);
      load(8'h11, 3'h7, 9'h005, 5'h10, 9'h000, 5'h00);
      rd(CMD_LOCAL_FRAC, 8'h20);
      $display("Test hold done");
      rd(CMD_R1S_WHOLE, 8'h05);
      load(8'h11, 3'h7, 9'h005, 5'h00, 9'h000, 5'h00);
      host.access(1'b0, CMD_R1S_FRAC, d, r);
      check({7'h0, r}, 8'h01);
      check({7'h0, hold[1]}, 8'h01);
      rd(CMD_R1S_FRAC, 8'h80);
      host.access(1'b0, CMD_LOCAL_WHOLE, d, r);
      rd(CMD_LOCAL_WHOLE, 8'h11);
      rd(8'h05, 8'h00);
      $display("Test writes done");
      end_of_test();
   end
endmodule

/* hw/temp_value_pkg.sv */
/*
 Constants, command codes and carrier types of the temperature value
 readout registers. Assumes a serial management bus front end that
 presents one decoded command byte per access on the system clock.
*/
// Contract
// (RULE1) Host reads the upper byte before the lower byte for one coherent value.
// (RULE2) Upper byte read copies that channel's lower byte into a holding copy.
// (RULE3) Reading the held lower byte releases the hold.
// (RULE4) A repeated upper read recaptures the lower byte, replacing the held one.
// (RULE5) Local upper byte is two's complement whole degrees, +127 to -128.
// (RULE6) Local reading is the value compared for the local over-temperature event.
// (RULE7) Lower byte bits 7, 6, 5 weigh one half, quarter, eighth degree.
// (RULE8) Each remote offers a signed reading at its own upper and lower codes.
// (RULE9) Remote lower bit 4 is zero unless filtering, then one sixteenth.
// (RULE10) Remote lower bit 3 is zero unless filtering, then one thirty-second.
// (RULE11) Local lower bits 4-0 and remote lower bits 2-0 always read zero.
// (RULE12) Each remote offers an unsigned reading, 0 to 255 degrees.
// (RULE13) All value registers are read-only; writes change nothing.
package temp_value_pkg;

   // ----------------------------------------
   // Sizes and pair indices
   // ----------------------------------------
   localparam int NUM_PAIRS = 5;
   localparam int PAIR_LOCAL = 0;
   localparam int PAIR_R1_SIGNED = 1;
   localparam int PAIR_R2_SIGNED = 2;
   localparam int PAIR_R1_UNSIGNED = 3;
   localparam int PAIR_R2_UNSIGNED = 4;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_LOCAL_WHOLE = 8'h10;
   localparam logic [7:0] CMD_R1S_WHOLE = 8'h11;
   localparam logic [7:0] CMD_R2S_WHOLE = 8'h12;
   localparam logic [7:0] CMD_R1U_WHOLE = 8'h19;
   localparam logic [7:0] CMD_R2U_WHOLE = 8'h1A;
   localparam logic [7:0] CMD_LOCAL_FRAC = 8'h20;
   localparam logic [7:0] CMD_R1S_FRAC = 8'h21;
   localparam logic [7:0] CMD_R2S_FRAC = 8'h22;
   localparam logic [7:0] CMD_R1U_FRAC = 8'h29;
   localparam logic [7:0] CMD_R2U_FRAC = 8'h2A;
   localparam logic [7:0] WHOLE_CMD [NUM_PAIRS] =
      '{CMD_LOCAL_WHOLE, CMD_R1S_WHOLE, CMD_R2S_WHOLE, CMD_R1U_WHOLE, CMD_R2U_WHOLE};
   localparam logic [7:0] FRAC_CMD [NUM_PAIRS] =
      '{CMD_LOCAL_FRAC, CMD_R1S_FRAC, CMD_R2S_FRAC, CMD_R1U_FRAC, CMD_R2U_FRAC};

   // ----------------------------------------
   // Field values and masks
   // ----------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] SIGNED_MAX_WHOLE = 8'h7F;
   localparam logic [7:0] SIGNED_MIN_WHOLE = 8'h80;
   localparam logic [7:0] UNSIGNED_MAX_WHOLE = 8'hFF;
   localparam logic [7:0] FRAC_MASK_COARSE = 8'hE0;
   localparam logic [7:0] FRAC_MASK_FINE = 8'hF8;
   localparam logic [4:0] FRAC_FULL = 5'h1F;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] whole;
      logic [2:0] frac;
   } local_sample_type;

   typedef struct packed {
      logic [8:0] whole_ext;
      logic [4:0] frac;
   } remote_sample_type;

   typedef struct packed {
      local_sample_type local_s;
      remote_sample_type [1:0] remote_s;
   } conv_result_type;

   typedef struct packed {
      logic [7:0] whole;
      logic [7:0] frac;
   } reg_pair_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] cmd;
   } reg_req_type;

   typedef struct packed {
      logic ack;
      logic wr_refused;
      logic [7:0] data;
   } reg_rsp_type;

endpackage

/* hw/temp_value_readout_regs.sv */
/*
 Read-only temperature value registers for one local and two remote
 channels, with upper-byte-read locking of the lower byte.
 Assumes conversion results and filter enables come from logic on the
 same clock, and that the bus front end issues one access per cycle.
*/
`timescale 1ns/1ns
module temp_value_readout_regs (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire temp_value_pkg::conv_result_type conv_i,
   input wire logic conv_valid_i,
   input wire logic [1:0] filt_en_i,
   input wire logic [7:0] local_limit_i,
   input wire temp_value_pkg::reg_req_type req_i,
   output temp_value_pkg::reg_rsp_type rsp_o,
   output logic local_over_o,
   output logic [temp_value_pkg::NUM_PAIRS-1:0] hold_active_o
);
   import temp_value_pkg::*;

   // ----------------------------------------
   // Assertion clock
   // ----------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------
   // Latest conversion results
   // ----------------------------------------
   conv_result_type conv_r;
   reg_pair_type live_pair [NUM_PAIRS];
   logic [NUM_PAIRS-1:0] upper_hit;
   logic [NUM_PAIRS-1:0] lower_hit;
   logic [NUM_PAIRS-1:0] lock_r;
   logic [7:0] held_r [NUM_PAIRS];
   logic mapped;
   logic [7:0] rd_data_nxt;
   reg_rsp_type rsp_r;
   logic local_over_r;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         conv_r <= '0;
      end else if (conv_valid_i) begin
         conv_r <= conv_i;
      end
   end

   // ----------------------------------------
   // Format helpers
   // ----------------------------------------
   function automatic logic [7:0] remote_frac(input logic [4:0] f, input logic filt);
      logic [7:0] raw;
      raw = {f, 3'h0};
      remote_frac = raw & (filt ? FRAC_MASK_FINE : FRAC_MASK_COARSE); // RULE9 RULE10 RULE11
   endfunction

   function automatic reg_pair_type signed_pair(input remote_sample_type s, input logic filt);
      reg_pair_type p;
      p.whole = s.whole_ext[7:0];
      p.frac = remote_frac(s.frac, filt);
      if (s.whole_ext[8] && !s.whole_ext[7]) begin
         p.whole = SIGNED_MIN_WHOLE;
         p.frac = BYTE_ZERO;
      end else if (!s.whole_ext[8] && s.whole_ext[7]) begin
         p.whole = SIGNED_MAX_WHOLE;
         p.frac = remote_frac(FRAC_FULL, filt);
      end
      signed_pair = p; // RULE8
   endfunction

   function automatic reg_pair_type unsigned_pair(input remote_sample_type s, input logic filt);
      reg_pair_type p;
      p.whole = s.whole_ext[7:0];
      p.frac = remote_frac(s.frac, filt);
      if (s.whole_ext[8]) begin
         p.whole = BYTE_ZERO;
         p.frac = BYTE_ZERO;
      end
      unsigned_pair = p; // RULE12
   endfunction

   // ----------------------------------------
   // Live register values
   // ----------------------------------------
   always_comb begin
      live_pair[PAIR_LOCAL].whole = conv_r.local_s.whole; // RULE5
      live_pair[PAIR_LOCAL].frac = {conv_r.local_s.frac, 5'h00}; // RULE7 RULE11
      live_pair[PAIR_R1_SIGNED] = signed_pair(conv_r.remote_s[0], filt_en_i[0]);
      live_pair[PAIR_R2_SIGNED] = signed_pair(conv_r.remote_s[1], filt_en_i[1]);
      live_pair[PAIR_R1_UNSIGNED] = unsigned_pair(conv_r.remote_s[0], filt_en_i[0]);
      live_pair[PAIR_R2_UNSIGNED] = unsigned_pair(conv_r.remote_s[1], filt_en_i[1]);
   end

   // ----------------------------------------
   // Lower byte hold per pair
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
         assign upper_hit[gi] = req_i.rd && (req_i.cmd == WHOLE_CMD[gi]);
         assign lower_hit[gi] = req_i.rd && (req_i.cmd == FRAC_CMD[gi]);

         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               lock_r[gi] <= 1'b0;
               held_r[gi] <= BYTE_ZERO;
            end else if (upper_hit[gi]) begin
               lock_r[gi] <= 1'b1; // RULE1 RULE2 RULE4
               held_r[gi] <= live_pair[gi].frac; // RULE2 RULE4
            end else if (lower_hit[gi]) begin
               lock_r[gi] <= 1'b0; // RULE3
            end
         end

         a_hold_capture: assert property (upper_hit[gi] |=> lock_r[gi] && held_r[gi] == $past(live_pair[gi].frac)) // RULE2
            else $error("upper read did not capture lower byte");

         a_hold_release: assert property (lower_hit[gi] |=> !lock_r[gi]) // RULE3
            else $error("lower read did not release hold");

         a_hold_stays: assert property (lock_r[gi] && !lower_hit[gi] && !upper_hit[gi] |=> lock_r[gi] && $stable(held_r[gi])) // RULE2
            else $error("held lower byte changed without access");

         a_held_returned: assert property (lower_hit[gi] && lock_r[gi] |=> rsp_o.ack && rsp_o.data == $past(held_r[gi])) // RULE2
            else $error("held lower byte not returned");

         a_upper_data: assert property (upper_hit[gi] |=> // RULE5 RULE8 RULE12
               rsp_o.ack && rsp_o.data == $past(live_pair[gi].whole))
            else $error("upper byte read returned wrong value");

         a_live_returned: assert property (lower_hit[gi] && !lock_r[gi] |=> // RULE3
               rsp_o.ack && rsp_o.data == $past(live_pair[gi].frac))
            else $error("released lower byte not live");

         a_lock_source: assert property (!lock_r[gi] && !upper_hit[gi] |=> !lock_r[gi]) // RULE2
            else $error("hold set without upper read");

         a_held_vs_conv: assert property (lock_r[gi] && conv_valid_i && !upper_hit[gi] |=> $stable(held_r[gi])) // RULE2
            else $error("new conversion disturbed held byte");
      end
   endgenerate

   assign hold_active_o = lock_r;

   // ----------------------------------------
   // Read data select
   // ----------------------------------------
   always_comb begin
      rd_data_nxt = BYTE_ZERO;
      mapped = 1'b0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         if (upper_hit[i]) begin
            rd_data_nxt = live_pair[i].whole;
            mapped = 1'b1;
         end
         if (lower_hit[i]) begin
            rd_data_nxt = lock_r[i] ? held_r[i] : live_pair[i].frac;
            mapped = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rsp_r <= '0;
      end else begin
         rsp_r.ack <= req_i.rd || req_i.wr;
         rsp_r.wr_refused <= req_i.wr && !req_i.rd; // RULE13
         if (req_i.rd) begin
            rsp_r.data <= rd_data_nxt;
         end
      end
   end

   assign rsp_o = rsp_r;

   // ----------------------------------------
   // Local over-temperature compare
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         local_over_r <= 1'b0;
      end else begin
         local_over_r <= $signed(conv_r.local_s.whole) > $signed(local_limit_i); // RULE6
      end
   end

   assign local_over_o = local_over_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------

   a_local_whole: assert property (req_i.rd && req_i.cmd == CMD_LOCAL_WHOLE |=> // RULE5
         rsp_o.data == $past(conv_r.local_s.whole))
      else $error("local upper byte wrong");

   a_local_frac: assert property (req_i.rd && req_i.cmd == CMD_LOCAL_FRAC && !lock_r[PAIR_LOCAL] |=> // RULE7
         rsp_o.data[7:5] == $past(conv_r.local_s.frac))
      else $error("local fraction weights wrong");

   a_local_low_zero: assert property (req_i.rd && req_i.cmd == CMD_LOCAL_FRAC |=> // RULE11
         rsp_o.data[4:0] == 5'h00)
      else $error("local lower reserved bits not zero");

   a_remote_low_zero: assert property (req_i.rd && (req_i.cmd == CMD_R1S_FRAC || req_i.cmd == CMD_R2U_FRAC) |=> // RULE11
         rsp_o.data[2:0] == 3'h0)
      else $error("remote lower reserved bits not zero");

   a_filter_off_b4: assert property (req_i.rd && req_i.cmd == CMD_R1S_FRAC && !filt_en_i[0] && !lock_r[PAIR_R1_SIGNED]
         |=> !rsp_o.data[4]) // RULE9
      else $error("fine bit 4 set with filter off");

   a_filter_on_b3: assert property (req_i.rd && req_i.cmd == CMD_R2S_FRAC && filt_en_i[1] && !lock_r[PAIR_R2_SIGNED]
         && conv_r.remote_s[1].whole_ext[8] == conv_r.remote_s[1].whole_ext[7]
         |=> rsp_o.data[4:3] == $past(conv_r.remote_s[1].frac[1:0])) // RULE10
      else $error("fine bits lost with filter on");

   a_signed_clamp: assert property (req_i.rd && req_i.cmd == CMD_R1S_WHOLE
         && conv_r.remote_s[0].whole_ext[8:7] == 2'b01 |=> rsp_o.data == SIGNED_MAX_WHOLE) // RULE8
      else $error("signed remote reading not clamped");

   a_unsigned_floor: assert property (req_i.rd && req_i.cmd == CMD_R2U_WHOLE
         && conv_r.remote_s[1].whole_ext[8] |=> rsp_o.data == BYTE_ZERO) // RULE12
      else $error("unsigned remote reading below zero");

   a_over_compare: assert property (##1 local_over_o == // RULE6
         ($signed($past(conv_r.local_s.whole)) > $signed($past(local_limit_i))))
      else $error("local over-temperature flag wrong");

   a_write_inert: assert property (req_i.wr && !req_i.rd |=> // RULE13
         rsp_o.wr_refused && $stable(rsp_o.data) && lock_r == $past(lock_r))
      else $error("write altered value registers");

   // ----------------------------------------
   // Bus answer checks
   // ----------------------------------------

   a_ack_follows: assert property (req_i.rd || req_i.wr |=> // RULE13
         rsp_o.ack)
      else $error("request not acknowledged");

   a_ack_idle: assert property (!req_i.rd && !req_i.wr |=> // RULE13
         !rsp_o.ack)
      else $error("acknowledge without request");

   a_read_accepted: assert property (req_i.rd |=> // RULE13
         !rsp_o.wr_refused)
      else $error("read flagged as refused write");

   a_data_stands: assert property (!req_i.rd |=> // RULE13
         $stable(rsp_o.data))
      else $error("read data changed without read");

   a_unmapped_zero: assert property (req_i.rd && upper_hit == '0 && lower_hit == '0 |=> // RULE13
         rsp_o.data == BYTE_ZERO)
      else $error("unmapped read not zero");

   a_write_keeps_held: assert property (req_i.wr && !req_i.rd |=> // RULE13
         $stable(held_r[PAIR_LOCAL]) && $stable(held_r[PAIR_R1_SIGNED]))
      else $error("write altered held byte");

   // ----------------------------------------
   // Fraction bit checks
   // ----------------------------------------

   a_r2s_low_zero: assert property (req_i.rd && req_i.cmd == CMD_R2S_FRAC |=> // RULE11
         rsp_o.data[2:0] == 3'h0)
      else $error("remote 2 signed reserved bits not zero");

   a_r1u_low_zero: assert property (req_i.rd && req_i.cmd == CMD_R1U_FRAC |=> // RULE11
         rsp_o.data[2:0] == 3'h0)
      else $error("remote 1 unsigned reserved bits not zero");

   a_r1s_off_b3: assert property (req_i.rd && req_i.cmd == CMD_R1S_FRAC && !filt_en_i[0] && !lock_r[PAIR_R1_SIGNED] |=> // RULE10
         !rsp_o.data[3])
      else $error("fine bit 3 set with filter off");

   a_r2s_off_b4: assert property (req_i.rd && req_i.cmd == CMD_R2S_FRAC && !filt_en_i[1] && !lock_r[PAIR_R2_SIGNED] |=> // RULE9
         !rsp_o.data[4])
      else $error("fine bit 4 set with filter off");

   a_r1u_off_b4: assert property (req_i.rd && req_i.cmd == CMD_R1U_FRAC && !filt_en_i[0] && !lock_r[PAIR_R1_UNSIGNED] |=> // RULE9
         !rsp_o.data[4])
      else $error("fine bit 4 set with filter off");

   a_r2u_off_b3: assert property (req_i.rd && req_i.cmd == CMD_R2U_FRAC && !filt_en_i[1] && !lock_r[PAIR_R2_UNSIGNED] |=> // RULE10
         !rsp_o.data[3])
      else $error("fine bit 3 set with filter off");

   a_r1u_on_b4: assert property (req_i.rd && req_i.cmd == CMD_R1U_FRAC && filt_en_i[0] && !lock_r[PAIR_R1_UNSIGNED]
         && !conv_r.remote_s[0].whole_ext[8] |=> rsp_o.data[4] == $past(conv_r.remote_s[0].frac[1])) // RULE9
      else $error("fine bit 4 lost with filter on");

   a_r2u_on_b3: assert property (req_i.rd && req_i.cmd == CMD_R2U_FRAC && filt_en_i[1] && !lock_r[PAIR_R2_UNSIGNED]
         && !conv_r.remote_s[1].whole_ext[8] |=> rsp_o.data[3] == $past(conv_r.remote_s[1].frac[0])) // RULE10
      else $error("fine bit 3 lost with filter on");

   a_r1s_weights: assert property (req_i.rd && req_i.cmd == CMD_R1S_FRAC && !lock_r[PAIR_R1_SIGNED] // RULE7
         && conv_r.remote_s[0].whole_ext[8] == conv_r.remote_s[0].whole_ext[7]
         |=> rsp_o.data[7:5] == $past(conv_r.remote_s[0].frac[4:2]))
      else $error("remote 1 fraction weights wrong");

   a_r2u_weights: assert property (req_i.rd && req_i.cmd == CMD_R2U_FRAC && !lock_r[PAIR_R2_UNSIGNED] // RULE7
         && !conv_r.remote_s[1].whole_ext[8] |=> rsp_o.data[7:5] == $past(conv_r.remote_s[1].frac[4:2]))
      else $error("remote 2 fraction weights wrong");

   a_clamp_frac_max: assert property (req_i.rd && req_i.cmd == CMD_R1S_FRAC && !lock_r[PAIR_R1_SIGNED] // RULE8
         && !filt_en_i[0] && conv_r.remote_s[0].whole_ext[8:7] == 2'b01 |=> rsp_o.data == FRAC_MASK_COARSE)
      else $error("clamped fraction not at maximum");

   // ----------------------------------------
   // Range checks
   // ----------------------------------------

   a_r1s_pass: assert property (req_i.rd && req_i.cmd == CMD_R1S_WHOLE // RULE8
         && conv_r.remote_s[0].whole_ext[8] == conv_r.remote_s[0].whole_ext[7]
         |=> rsp_o.data == $past(conv_r.remote_s[0].whole_ext[7:0]))
      else $error("remote 1 signed reading wrong");

   a_r2s_pass: assert property (req_i.rd && req_i.cmd == CMD_R2S_WHOLE // RULE8
         && conv_r.remote_s[1].whole_ext[8] == conv_r.remote_s[1].whole_ext[7]
         |=> rsp_o.data == $past(conv_r.remote_s[1].whole_ext[7:0]))
      else $error("remote 2 signed reading wrong");

   a_r2s_clamp_low: assert property (req_i.rd && req_i.cmd == CMD_R2S_WHOLE // RULE8
         && conv_r.remote_s[1].whole_ext[8:7] == 2'b10 |=> rsp_o.data == SIGNED_MIN_WHOLE)
      else $error("signed remote reading not clamped low");

   a_r1u_pass: assert property (req_i.rd && req_i.cmd == CMD_R1U_WHOLE && !conv_r.remote_s[0].whole_ext[8] // RULE12
         |=> rsp_o.data == $past(conv_r.remote_s[0].whole_ext[7:0]))
      else $error("remote 1 unsigned reading wrong");

   a_r1u_floor: assert property (req_i.rd && req_i.cmd == CMD_R1U_WHOLE && conv_r.remote_s[0].whole_ext[8] // RULE12
         |=> rsp_o.data == BYTE_ZERO)
      else $error("remote 1 unsigned reading below zero");

   a_r2u_pass: assert property (req_i.rd && req_i.cmd == CMD_R2U_WHOLE && !conv_r.remote_s[1].whole_ext[8] // RULE12
         |=> rsp_o.data == $past(conv_r.remote_s[1].whole_ext[7:0]))
      else $error("remote 2 unsigned reading wrong");

   // ----------------------------------------
   // Limit checks
   // ----------------------------------------

   a_over_min_limit: assert property (local_limit_i == SIGNED_MIN_WHOLE // RULE6
         && conv_r.local_s.whole != SIGNED_MIN_WHOLE |=> local_over_o)
      else $error("local reading above minimum limit not flagged");

   c_lock_then_read: cover property (upper_hit[PAIR_LOCAL] ##[1:8] lower_hit[PAIR_LOCAL]);
   c_double_upper: cover property (upper_hit[PAIR_R1_SIGNED] ##[1:8] upper_hit[PAIR_R1_SIGNED]);
   c_conv_while_held: cover property (lock_r[PAIR_R2_UNSIGNED] && conv_valid_i);
   c_write_refused: cover property (rsp_o.wr_refused);
   c_clamped_read: cover property (upper_hit[PAIR_R2_SIGNED] && conv_r.remote_s[1].whole_ext[8:7] == 2'b01);

endmodule
